// ===== design/relay_pkg.sv
// package: constants, register map and types for the alarm output relay block
// assumes a 40 MHz reference clock and an AXI4-Lite register bus with 32-bit data
package relay_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int NUM_CHAN = 8;
  localparam int NUM_OUT = 2;
  localparam int TIME_W = 14;
  localparam logic [13:0] TIME_MAX = 14'd9999;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ALARM = 8'h04;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h10;
  localparam logic [7:0] ADDR_OUT_STRIDE = 8'h10;
  // per-output register slots within its stride
  localparam logic [3:0] SLOT_CTRL = 4'h0;
  localparam logic [3:0] SLOT_DLY = 4'h4;
  localparam logic [3:0] SLOT_HOLD = 4'h8;
  localparam logic [3:0] SLOT_SRC = 4'hC;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FUNC_BIT = 2;
  localparam int DLY_OPEN_LSB = 16;
  localparam int HOLD_OPEN_LSB = 16;
  localparam int SRC_W = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {MODE_OFF, MODE_NO, MODE_NC} mode_e;
  typedef enum logic [2:0] {SRC_NONE, SRC_AL1, SRC_AL2, SRC_EITHER, SRC_BOTH} src_e;
  typedef enum logic [1:0] {ST_OPEN, ST_ARMING, ST_ACTIVE, ST_RELEASING} relay_state_e;
endpackage

// ===== design/relay_cfg_if.sv
// interface: configuration and state of one relay output channel
// assumes the controller and the output channel share the reference clock
`timescale 1ns/100ps
`default_nettype none
interface relay_cfg_if;
  import relay_pkg::*;
  logic [1:0] mode;
  logic andFunc;
  logic [TIME_W-1:0] closeDelay;
  logic [TIME_W-1:0] openDelay;
  logic [TIME_W-1:0] closedHold;
  logic [TIME_W-1:0] openHold;
  logic [NUM_CHAN*SRC_W-1:0] srcSel;
  logic relayClosed;
  modport ctrl (output mode, andFunc, closeDelay, openDelay, closedHold, openHold, srcSel,
    input relayClosed);
  modport chan (input mode, andFunc, closeDelay, openDelay, closedHold, openHold, srcSel,
    output relayClosed);
endinterface
`default_nettype wire

// ===== design/relay_output.sv
// module: one relay output with source selection, combining, delays and hold times
// assumes alarm inputs are already synchronous to ref_clk and secTick is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module relay_output
  import relay_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic secTick,
  // alarms
  input wire logic [NUM_CHAN-1:0] alarm1,
  input wire logic [NUM_CHAN-1:0] alarm2,
  // configuration and state
  relay_cfg_if.chan cfg
);
  typedef struct packed {
    relay_state_e st;
    logic [TIME_W-1:0] cnt;
    logic [TIME_W-1:0] hold;
    logic active;
    logic relay;
  } out_s;

  out_s cur_ff;
  out_s nxt_cur;
  logic [NUM_CHAN-1:0] chanAlarm;
  logic [NUM_CHAN-1:0] chanUsed;
  logic request;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chanUsed[i] = 1'b1;
      case (src_e'(cfg.srcSel[i*SRC_W +: SRC_W]))
        SRC_AL1: chanAlarm[i] = alarm1[i];
        SRC_AL2: chanAlarm[i] = alarm2[i];
        SRC_EITHER: chanAlarm[i] = alarm1[i] | alarm2[i];
        SRC_BOTH: chanAlarm[i] = alarm1[i] & alarm2[i];
        default: begin
          chanAlarm[i] = 1'b0;
          chanUsed[i] = 1'b0;
        end
      endcase
    end
    if (cfg.andFunc) begin
      request = (chanUsed != '0) && ((chanAlarm | ~chanUsed) == '1);
    end else begin
      request = |chanAlarm;
    end
    if (mode_e'(cfg.mode) == MODE_OFF) begin
      request = 1'b0;
    end
  end

  // delay counters go up while the condition holds and down while it is away, so a
  // condition present more than half the time still reaches the limit
  always_comb begin
    nxt_cur = cur_ff;
    if (cur_ff.hold != '0 && secTick) begin
      nxt_cur.hold = cur_ff.hold - 1'b1;
    end
    case (cur_ff.st)
      ST_OPEN: begin
        if (request && cur_ff.hold == '0) begin
          nxt_cur.st = ST_ARMING;
          nxt_cur.cnt = '0;
        end
      end
      ST_ARMING: begin
        if (cur_ff.cnt >= cfg.closeDelay) begin
          nxt_cur.st = ST_ACTIVE;
          nxt_cur.active = 1'b1;
          nxt_cur.hold = cfg.closedHold;
        end else if (secTick) begin
          if (request) begin
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
          end else if (cur_ff.cnt == '0) begin
            nxt_cur.st = ST_OPEN;
          end else begin
            nxt_cur.cnt = cur_ff.cnt - 1'b1;
          end
        end
      end
      ST_ACTIVE: begin
        if (!request && cur_ff.hold == '0) begin
          nxt_cur.st = ST_RELEASING;
          nxt_cur.cnt = '0;
        end
      end
      ST_RELEASING: begin
        if (cur_ff.cnt >= cfg.openDelay) begin
          nxt_cur.st = ST_OPEN;
          nxt_cur.active = 1'b0;
          nxt_cur.hold = cfg.openHold;
        end else if (secTick) begin
          if (!request) begin
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
          end else if (cur_ff.cnt == '0) begin
            nxt_cur.st = ST_ACTIVE;
          end else begin
            nxt_cur.cnt = cur_ff.cnt - 1'b1;
          end
        end
      end
      default: nxt_cur.st = ST_OPEN;
    endcase
    case (mode_e'(cfg.mode))
      MODE_NO: nxt_cur.relay = nxt_cur.active;
      MODE_NC: nxt_cur.relay = ~nxt_cur.active;
      default: begin
        nxt_cur.relay = 1'b0;
        nxt_cur.st = ST_OPEN;
        nxt_cur.active = 1'b0;
        nxt_cur.hold = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '{st: ST_OPEN, cnt: '0, hold: '0, active: 1'b0, relay: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cfg.relayClosed = cur_ff.relay;
endmodule
`default_nettype wire

// ===== design/alarm_output_relay_logic.sv
// top: alarm output relay logic with AXI4-Lite register access
// assumes alarm flags come from outside the clock domain and are synchronised here
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module alarm_output_relay_logic
  import relay_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // alarm flags
  input wire logic [NUM_CHAN-1:0] alarm1,
  input wire logic [NUM_CHAN-1:0] alarm2,
  // relay drives
  output logic [NUM_OUT-1:0] relayClosed,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [NUM_CHAN-1:0] a1Meta;
    logic [NUM_CHAN-1:0] a1Sync;
    logic [NUM_CHAN-1:0] a2Meta;
    logic [NUM_CHAN-1:0] a2Sync;
    logic [31:0] prescale;
    logic tick;
    logic [NUM_OUT-1:0][31:0] ctrl;
    logic [NUM_OUT-1:0][31:0] dly;
    logic [NUM_OUT-1:0][31:0] hold;
    logic [NUM_OUT-1:0][31:0] src;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [NUM_OUT-1:0] relay;
  } top_s;

  top_s cur_ff;
  top_s nxt_cur;
  logic [NUM_OUT-1:0] chanRelay;

  // clamp a seconds field to the documented top value
  function automatic logic [TIME_W-1:0] clampTime(input logic [15:0] v);
    logic [TIME_W-1:0] r;
    r = (v > 16'(TIME_MAX)) ? TIME_MAX : v[TIME_W-1:0];
    return r;
  endfunction

  // merge a write word into a register through the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // decode an address: out index, slot and whether it hits a per-output register
  function automatic logic hitOut(input logic [7:0] a, output logic [0:0] idx,
    output logic [3:0] slot);
    logic [7:0] off;
    off = a - ADDR_OUT_BASE;
    idx = off[4];
    slot = off[3:0];
    return (a >= ADDR_OUT_BASE) && (off < 8'(NUM_OUT) * ADDR_OUT_STRIDE) && (off[1:0] == 2'b00);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gOut
      relay_cfg_if cfgIf ();
      assign cfgIf.mode = cur_ff.ctrl[g][CTRL_MODE_LSB +: 2];
      assign cfgIf.andFunc = cur_ff.ctrl[g][CTRL_FUNC_BIT];
      assign cfgIf.closeDelay = clampTime(cur_ff.dly[g][15:0]);
      assign cfgIf.openDelay = clampTime(cur_ff.dly[g][DLY_OPEN_LSB +: 16]);
      assign cfgIf.closedHold = clampTime(cur_ff.hold[g][15:0]);
      assign cfgIf.openHold = clampTime(cur_ff.hold[g][HOLD_OPEN_LSB +: 16]);
      assign cfgIf.srcSel = cur_ff.src[g][NUM_CHAN*SRC_W-1:0];
      assign chanRelay[g] = cfgIf.relayClosed;
      relay_output uOut (
        .ref_clk(ref_clk),
        .rst(rst),
        .secTick(cur_ff.tick),
        .alarm1(cur_ff.a1Sync),
        .alarm2(cur_ff.a2Sync),
        .cfg(cfgIf.chan)
      );
    end
  endgenerate

  always_comb begin
    logic [0:0] wIdx;
    logic [3:0] wSlot;
    logic [0:0] rIdx;
    logic [3:0] rSlot;
    logic wHit;
    logic rHit;
    nxt_cur = cur_ff;
    wIdx = '0;
    wSlot = '0;
    rIdx = '0;
    rSlot = '0;
    wHit = 1'b0;
    rHit = 1'b0;
    nxt_cur.a1Meta = alarm1;
    nxt_cur.a1Sync = cur_ff.a1Meta;
    nxt_cur.a2Meta = alarm2;
    nxt_cur.a2Sync = cur_ff.a2Meta;
    nxt_cur.relay = chanRelay;
    // one-second tick; the exact count makes intervals no longer than set
    nxt_cur.tick = 1'b0;
    if (cur_ff.prescale >= 32'(TickCycles - 1)) begin
      nxt_cur.prescale = '0;
      nxt_cur.tick = 1'b1;
    end else begin
      nxt_cur.prescale = cur_ff.prescale + 32'd1;
    end
    // write path
    if (s_axi_awvalid && !cur_ff.awHave) begin
      nxt_cur.awHave = 1'b1;
      nxt_cur.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_ff.wHave) begin
      nxt_cur.wHave = 1'b1;
      nxt_cur.wData = s_axi_wdata;
      nxt_cur.wStrb = s_axi_wstrb;
    end
    if (cur_ff.awHave && cur_ff.wHave && !cur_ff.bValid) begin
      wHit = hitOut(cur_ff.awAddr, wIdx, wSlot);
      nxt_cur.awHave = 1'b0;
      nxt_cur.wHave = 1'b0;
      nxt_cur.bValid = 1'b1;
      nxt_cur.bResp = wHit ? RESP_OKAY : RESP_SLVERR;
      if (wHit) begin
        case (wSlot)
          SLOT_CTRL: nxt_cur.ctrl[wIdx] = merge(cur_ff.ctrl[wIdx], cur_ff.wData, cur_ff.wStrb);
          SLOT_DLY: nxt_cur.dly[wIdx] = merge(cur_ff.dly[wIdx], cur_ff.wData, cur_ff.wStrb);
          SLOT_HOLD: nxt_cur.hold[wIdx] = merge(cur_ff.hold[wIdx], cur_ff.wData, cur_ff.wStrb);
          default: nxt_cur.src[wIdx] = merge(cur_ff.src[wIdx], cur_ff.wData, cur_ff.wStrb);
        endcase
      end
    end
    if (cur_ff.bValid && s_axi_bready) begin
      nxt_cur.bValid = 1'b0;
    end
    // read path
    if (s_axi_arvalid && !cur_ff.rValid) begin
      rHit = hitOut(s_axi_araddr, rIdx, rSlot);
      nxt_cur.rValid = 1'b1;
      nxt_cur.rResp = RESP_OKAY;
      if (s_axi_araddr == ADDR_STATUS) begin
        nxt_cur.rData = 32'(cur_ff.relay);
      end else if (s_axi_araddr == ADDR_ALARM) begin
        nxt_cur.rData = {16'h0000, cur_ff.a2Sync, cur_ff.a1Sync};
      end else if (rHit) begin
        case (rSlot)
          SLOT_CTRL: nxt_cur.rData = cur_ff.ctrl[rIdx];
          SLOT_DLY: nxt_cur.rData = cur_ff.dly[rIdx];
          SLOT_HOLD: nxt_cur.rData = cur_ff.hold[rIdx];
          default: nxt_cur.rData = cur_ff.src[rIdx];
        endcase
      end else begin
        nxt_cur.rData = RESET_WORD;
        nxt_cur.rResp = RESP_SLVERR;
      end
    end else if (cur_ff.rValid && s_axi_rready) begin
      nxt_cur.rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign s_axi_awready = !cur_ff.awHave;
  assign s_axi_wready = !cur_ff.wHave;
  assign s_axi_bvalid = cur_ff.bValid;
  assign s_axi_bresp = cur_ff.bResp;
  assign s_axi_arready = !cur_ff.rValid;
  assign s_axi_rvalid = cur_ff.rValid;
  assign s_axi_rdata = cur_ff.rData;
  assign s_axi_rresp = cur_ff.rResp;
  assign relayClosed = cur_ff.relay;
endmodule
`default_nettype wire

// ===== verif/relay_properties.sv
// checker: bus handshake, latency and status properties of the relay block
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module relay_properties
  import relay_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // relay drives
  input wire logic [NUM_OUT-1:0] relayClosed,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic rdTake = s_axi_arvalid && s_axi_arready;

  reset_open_a: assert property (disable iff (1'b0) rst |=> relayClosed == '0
    && !s_axi_bvalid && !s_axi_rvalid) else $error("relay or response active after reset");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response not held");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
  read_lat_a: assert property (rdTake |=> s_axi_rvalid) else $error("read answer late");
  write_hold_a: assert property (wrTake |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while held");
  write_lat_a: assert property (wrTake |=> ##1 s_axi_bvalid) else $error("write answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  status_word_a: assert property (rdTake && s_axi_araddr == ADDR_STATUS |=>
    s_axi_rdata == {30'h0, $past(relayClosed)}) else $error("status word wrong");
  unmapped_a: assert property (rdTake && s_axi_araddr == 8'h08 |=> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == '0) else $error("unmapped read not refused");

  cover property (wrTake ##2 s_axi_bvalid && s_axi_bready);
  cover property (rdTake && s_axi_araddr == ADDR_STATUS);
  cover property ($rose(relayClosed[0]));
  cover property ($rose(relayClosed[1]));
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// testbench: drives alarms and the AXI4-Lite bus, checks every answer from a queue of notes
// assumes a 10-cycle second tick so that delays and holds run in tens of cycles
`timescale 1ns/100ps
`default_nettype none
module testbench
  import relay_pkg::*;
;
  logic ref_clk = 0, rst = 1;
  logic [7:0] alarm1 = '0, alarm2 = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [NUM_OUT-1:0] relayClosed;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, num_checks = 0;

  alarm_output_relay_logic #(.TickCycles(10)) i_alarm_output_relay_logic (.*);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic cmpResp(input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // oldest note is compared whenever a response is handed over
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmpResp(bq.pop_front(), s_axi_bresp);
  end

  // ready is raised after a random stall and held until the answer is seen
  task automatic answer(input bit isRead);
    int n;
    repeat ($urandom % 3) @(posedge ref_clk);
    if (isRead) s_axi_rready <= 1;
    else s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(isRead ? s_axi_rvalid : s_axi_bvalid) && n < 50);
    s_axi_rready <= 0;
    s_axi_bready <= 0;
    tmo(n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 50);
    tmo(n);
    answer(0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 0;
    tmo(n);
    answer(1);
  endtask

  task automatic st(input logic [1:0] e);
    repeat (8) @(posedge ref_clk);
    rd(ADDR_STATUS, {30'h0, e});
  endtask

  initial begin
    logic a, e;
    void'($urandom(66));
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_OUT_BASE, 32'h0);
    rd(8'h08, 32'h0, RESP_SLVERR);
    rd(8'h11, 32'h0, RESP_SLVERR);
    wr(8'h08, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'h3;
    wr(8'h14, 32'h0000_0005);
    s_axi_wstrb <= 4'hF;
    rd(8'h14, 32'hFFFF_0005);
    wr(8'h14, 32'h0);
    // output 2 combines channels 1 and 2 on alarm 1
    wr(8'h2C, 32'h0000_0009);
    for (int f = 0; f < 2; f++) begin
      wr(8'h20, {29'h0, f[0], 2'h1});
      for (int p = 0; p < 4; p++) begin
        alarm1 <= {6'($urandom), 2'(p)};
        e = f ? (p == 3) : (p != 0);
        st({e, 1'b0});
      end
    end
    rd(ADDR_ALARM, {16'h0, alarm2, alarm1});
    wr(8'h20, 32'h0);
    // output 1: every mode code against every source code on channel 1
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OUT_BASE, 32'(m));
      for (int s = 0; s < 8; s++) begin
        wr(8'h1C, 32'(s));
        for (int p = 0; p < 4; p++) begin
          alarm1 <= {7'($urandom), p[0]};
          alarm2 <= {7'($urandom), p[1]};
          a = s == 1 ? p[0] : s == 2 ? p[1] : s == 3 ? |p : s == 4 ? p == 3 : 1'b0;
          e = m == 1 ? a : m == 2 ? !a : 1'b0;
          st({1'b0, e});
        end
      end
    end
    alarm1 <= 8'h00;
    wr(8'h1C, 32'h0000_0001);
    wr(ADDR_OUT_BASE, 32'h0000_0001);
    wr(8'h14, 32'h0005_0005);
    st(2'h0);
    alarm1 <= 8'h01;
    st(2'h0);
    repeat (80) @(posedge ref_clk);
    st(2'h1);
    alarm1 <= 8'h00;
    st(2'h1);
    repeat (80) @(posedge ref_clk);
    st(2'h0);
    // request flickers faster than half the delay at about 70 percent duty
    repeat (40) begin
      alarm1 <= 8'h00;
      repeat (4) @(posedge ref_clk);
      alarm1 <= 8'h01;
      repeat (9) @(posedge ref_clk);
    end
    st(2'h1);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0003_0003);
    alarm1 <= 8'h00;
    repeat (6) @(posedge ref_clk);
    alarm1 <= 8'h01;
    st(2'h0);
    repeat (60) @(posedge ref_clk);
    st(2'h1);
    alarm1 <= 8'h00;
    repeat (60) @(posedge ref_clk);
    alarm1 <= 8'h01;
    repeat (6) @(posedge ref_clk);
    alarm1 <= 8'h00;
    st(2'h1);
    repeat (60) @(posedge ref_clk);
    st(2'h0);
    wrap_up();
  end
endmodule

bind alarm_output_relay_logic relay_properties i_relay_properties (.*);
`default_nettype wire
